// ### hs_channel_ctrl_indirect_regs_tb_top.sv
`timescale 1ns/10ps
module hs_channel_ctrl_indirect_regs_tb_top;
  import hsc_pkg::*;
  logic ref_clk, resetn, mgmt_c45, mgmt_wr, mgmt_rd, mgmt_rvalid;
  logic [15:0] mgmt_addr, mgmt_wdata, mgmt_rdata;
  logic [4:0] manual_pll_multiplier, manual_host_multiplier, pll_multiplier, host_side_multiplier;
  logic [1:0] manual_rate, side_rate;
  logic rx_tolerance_comp_skip, tx_tolerance_comp_skip, line_encoder_skip, line_decoder_skip;
  logic rx_symbol_valid, rx_code_error, align_match, sync_acquired;
  logic [9:0] rx_symbol;
  int n_errors = 0;
  int num_checks = 0;

  hsc_regs u_hsc_regs (.ref_clk, .resetn, .mgmt_c45, .mgmt_addr, .mgmt_wr, .mgmt_rd, .mgmt_wdata, .mgmt_rdata,
    .mgmt_rvalid, .manual_pll_multiplier, .manual_host_multiplier, .manual_rate, .pll_multiplier,
    .host_side_multiplier, .side_rate, .rx_tolerance_comp_skip, .tx_tolerance_comp_skip, .line_encoder_skip,
    .line_decoder_skip, .rx_symbol_valid, .rx_symbol, .rx_code_error, .align_match, .sync_acquired);
  hsc_mgmt_model u_hsc_mgmt_model (.ref_clk, .mgmt_c45, .mgmt_addr, .mgmt_wr, .mgmt_rd, .mgmt_wdata,
    .mgmt_rdata, .mgmt_rvalid);

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task rd(input logic c45, input logic [15:0] addr, input logic [15:0] exp);
    u_hsc_mgmt_model.xfer(c45, addr, 1'b0, 16'h0000, 0);
    chk({15'h0000, u_hsc_mgmt_model.last_ok}, 16'h0001);
    chk(u_hsc_mgmt_model.last_rdata, exp);
  endtask

  // Writes go out with one idle cycle in front, so the slow station is exercised as well.
  task wr(input logic c45, input logic [15:0] addr, input logic [15:0] data);
    u_hsc_mgmt_model.xfer(c45, addr, 1'b1, data, 1);
    chk({15'h0000, u_hsc_mgmt_model.last_ok}, 16'h0001);
  endtask

  task sym(input logic v, input logic [9:0] s, input logic e, input logic m, input logic sy);
    rx_symbol_valid = v;
    rx_symbol = s;
    rx_code_error = e;
    @(posedge ref_clk);
    #1;
    chk({14'h0000, align_match, sync_acquired}, {14'h0000, m, sy});
  endtask

  task rates(input logic [11:0] exp);
    @(posedge ref_clk);
    #1;
    chk({4'h0, pll_multiplier, host_side_multiplier, side_rate}, {4'h0, exp});
  endtask

  task t_reset;
    rates({HSC_AUTO_PLL_156, HSC_AUTO_HOST_156, HSC_AUTO_RATE});
    chk({12'h000, rx_tolerance_comp_skip, tx_tolerance_comp_skip, line_encoder_skip, line_decoder_skip},
        16'h0000);
    sym(1'b0, 10'h000, 1'b0, 1'b0, 1'b0);
    rd(1'b0, HSC_OFF_CTRL, HSC_RST_CTRL);
    rd(1'b0, HSC_OFF_PTR, HSC_RST_PTR);
    rd(1'b0, HSC_OFF_WIN, 16'h0000);
    rd(1'b1, HSC_OFF_POS, 16'h0283);
    rd(1'b1, HSC_OFF_NEG, 16'h017c);
    rd(1'b1, 16'h0005, 16'h0000);
  endtask

  task t_ctrl;
    logic [15:0] sk [4];
    sk = '{16'h0800, 16'h0400, 16'h0008, 16'h0004};
    for (int i = 0; i < 4; i++) begin
      wr(1'b1, HSC_OFF_CTRL, sk[i]);
      chk({12'h000, rx_tolerance_comp_skip, tx_tolerance_comp_skip, line_encoder_skip, line_decoder_skip},
          16'h0008 >> i);
    end
    wr(1'b1, HSC_OFF_CTRL, 16'h1000);
    rates({HSC_AUTO_PLL_312, HSC_AUTO_HOST_312, HSC_AUTO_RATE});
    wr(1'b1, HSC_OFF_CTRL, 16'h2000);
    rates({5'h15, 5'h0a, 2'h2});
    wr(1'b0, HSC_OFF_CTRL, 16'hffff);
    rates({5'h15, 5'h0a, 2'h2});
    rd(1'b0, HSC_OFF_CTRL, 16'hffff);
    wr(1'b0, HSC_OFF_CTRL, 16'h0000);
    rates({HSC_AUTO_PLL_156, HSC_AUTO_HOST_156, HSC_AUTO_RATE});
  endtask

  task t_indirect;
    u_hsc_mgmt_model.window(HSC_OFF_POS, 1'b1, 16'hfd55);
    rd(1'b1, HSC_OFF_POS, 16'h0155);
    rd(1'b0, HSC_OFF_WIN, 16'h0155);
    rd(1'b0, HSC_OFF_PTR, HSC_OFF_POS);
    rd(1'b0, HSC_OFF_POS, 16'h0000);
    wr(1'b1, HSC_OFF_NEG, 16'h0123);
    wr(1'b0, HSC_OFF_PTR, HSC_OFF_NEG);
    rd(1'b0, HSC_OFF_WIN, 16'h0123);
    u_hsc_mgmt_model.window(16'h0005, 1'b1, 16'h0077);
    rd(1'b0, HSC_OFF_WIN, 16'h0000);
    wr(1'b1, HSC_OFF_POS, {6'h00, HSC_RST_POS});
    // The negative character goes back through the window, so a window write reaches it too.
    u_hsc_mgmt_model.window(HSC_OFF_NEG, 1'b1, {6'h00, HSC_RST_NEG});
    rd(1'b1, HSC_OFF_NEG, {6'h00, HSC_RST_NEG});
    rd(1'b0, HSC_OFF_PTR, HSC_OFF_NEG);
  endtask

  // A gap with no valid symbol sits inside the run; it must neither count nor restart it.
  task acquire;
    sym(1'b1, HSC_RST_POS, 1'b0, 1'b1, 1'b0);
    sym(1'b0, HSC_RST_POS, 1'b0, 1'b0, 1'b0);
    sym(1'b1, HSC_RST_POS, 1'b0, 1'b1, 1'b0);
    sym(1'b1, HSC_RST_POS, 1'b0, 1'b1, 1'b1);
  endtask

  task t_sync;
    for (int p = 1; p < 4; p++) begin
      wr(1'b1, HSC_OFF_CTRL, 16'(p));
      acquire;
      repeat (p - 1) sym(1'b1, 10'h000, 1'b1, 1'b0, 1'b1);
      sym(1'b1, 10'h0aa, 1'b0, 1'b0, 1'b1);
      repeat (p - 1) sym(1'b1, 10'h000, 1'b1, 1'b0, 1'b1);
      sym(1'b1, 10'h000, 1'b1, 1'b0, 1'b0);
      sym(1'b0, 10'h000, 1'b0, 1'b0, 1'b0);
    end
    wr(1'b1, HSC_OFF_CTRL, 16'h0000);
    acquire;
    // Three errors, then a clean run that pays one back, so two more are needed to lose sync.
    repeat (3) sym(1'b1, 10'h000, 1'b1, 1'b0, 1'b1);
    repeat (4) sym(1'b1, 10'h0aa, 1'b0, 1'b0, 1'b1);
    sym(1'b1, 10'h000, 1'b1, 1'b0, 1'b1);
    sym(1'b1, 10'h000, 1'b1, 1'b0, 1'b0);
    sym(1'b1, HSC_RST_NEG, 1'b0, 1'b1, 1'b0);
    sym(1'b0, 10'h000, 1'b0, 1'b0, 1'b0);
  endtask

  task tally_and_finish;
    if (n_errors == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    resetn = 1'b0;
    manual_pll_multiplier = 5'h15;
    manual_host_multiplier = 5'h0a;
    manual_rate = 2'h2;
    rx_symbol_valid = 1'b0;
    rx_symbol = 10'h000;
    rx_code_error = 1'b0;
    repeat (20) @(posedge ref_clk);
    #1;
    resetn = 1'b1;
    t_reset;
    t_ctrl;
    t_indirect;
    t_sync;
    tally_and_finish;
  end

  // The whole run takes under two hundred cycles; this limit is far beyond it.
  initial begin
    #100000;
    n_errors++;
    tally_and_finish;
  end
endmodule

// ### hsc_mgmt_model.sv
`timescale 1ns/10ps
module hsc_mgmt_model (
  // Clock.
  input wire logic ref_clk,
  // Management request.
  output logic mgmt_c45,
  output logic [15:0] mgmt_addr,
  output logic mgmt_wr,
  output logic mgmt_rd,
  output logic [15:0] mgmt_wdata,
  // Management answer.
  input wire logic [15:0] mgmt_rdata,
  input wire logic mgmt_rvalid
);
  logic [15:0] last_rdata;
  logic last_ok;

  initial begin
    mgmt_c45 = 1'b1;
    mgmt_addr = 16'hffff;
    mgmt_wr = 1'b0;
    mgmt_rd = 1'b0;
    mgmt_wdata = 16'hffff;
  end

  // One decoded frame; idle cycles in front of it model a slow station.
  task automatic xfer(input logic c45, input logic [15:0] addr, input logic wr, input logic [15:0] wdata,
                      input int gap);
    repeat (gap) @(posedge ref_clk);
    @(posedge ref_clk);
    #1;
    mgmt_c45 = c45;
    mgmt_addr = addr;
    mgmt_wr = wr;
    mgmt_rd = !wr;
    mgmt_wdata = wdata;
    @(posedge ref_clk);
    #1;
    last_ok = (mgmt_rvalid === !wr);
    last_rdata = mgmt_rdata;
    mgmt_wr = 1'b0;
    mgmt_rd = 1'b0;
    // Released address and data lines carry the inverse, so a stale value can never pass for a live one.
    mgmt_addr = ~addr;
    mgmt_wdata = ~wdata;
  endtask

  task automatic window(input logic [15:0] ext, input logic wr, input logic [15:0] wdata);
    xfer(1'b0, 16'h001e, 1'b1, ext, 0);
    xfer(1'b0, 16'h001f, wr, wdata, 0);
  endtask
endmodule

// ### hsc_pkg.sv
package hsc_pkg;

  // Register addresses.
  localparam logic [15:0] HSC_OFF_CTRL = 16'h001d;
  localparam logic [15:0] HSC_OFF_PTR = 16'h001e;
  localparam logic [15:0] HSC_OFF_WIN = 16'h001f;
  localparam logic [15:0] HSC_OFF_POS = 16'h8003;
  localparam logic [15:0] HSC_OFF_NEG = 16'h8004;

  // Reset values.
  localparam logic [15:0] HSC_RST_CTRL = 16'h0000;
  localparam logic [15:0] HSC_RST_PTR = 16'h0000;
  localparam logic [9:0] HSC_RST_POS = 10'h283;
  localparam logic [9:0] HSC_RST_NEG = 10'h17c;

  // Control register field positions and alignment character width.
  localparam int HSC_BIT_MANUAL = 13;
  localparam int HSC_BIT_REFSEL = 12;
  localparam int HSC_BIT_RX_CTC = 11;
  localparam int HSC_BIT_TX_CTC = 10;
  localparam int HSC_BIT_ENC = 3;
  localparam int HSC_BIT_DEC = 2;
  localparam int HSC_POL_HI = 1;
  localparam int HSC_POL_LO = 0;
  localparam int HSC_CHAR_W = 10;

  // Sync loss policy codes.
  localparam logic [1:0] HSC_POL_STD = 2'b00;
  localparam logic [1:0] HSC_POL_ONE = 2'b01;
  localparam logic [1:0] HSC_POL_TWO = 2'b10;
  localparam logic [1:0] HSC_POL_THREE = 2'b11;

  // Derived rate settings; widths and values are plain defaults.
  localparam int HSC_MULT_W = 5;
  localparam int HSC_RATE_W = 2;
  localparam logic [4:0] HSC_AUTO_PLL_156 = 5'h10;
  localparam logic [4:0] HSC_AUTO_PLL_312 = 5'h08;
  localparam logic [4:0] HSC_AUTO_HOST_156 = 5'h08;
  localparam logic [4:0] HSC_AUTO_HOST_312 = 5'h04;
  localparam logic [1:0] HSC_AUTO_RATE = 2'h0;

  // Register select, one-hot.
  typedef enum logic [4:0] {
    HSC_SEL_NONE = 5'b00000,
    HSC_SEL_CTRL = 5'b00001,
    HSC_SEL_PTR = 5'b00010,
    HSC_SEL_WIN = 5'b00100,
    HSC_SEL_POS = 5'b01000,
    HSC_SEL_NEG = 5'b10000
  } hsc_sel_t;

  typedef enum logic [1:0] {
    HSC_LOST = 2'b01,
    HSC_SYNCED = 2'b10
  } hsc_sync_t;

endpackage

// ### hsc_regs.sv
`timescale 1ns/10ps
module hsc_regs #(
  parameter int unsigned ACQ_COUNT = 3,
  parameter int unsigned GOOD_RECOVER = 4,
  parameter int unsigned ERR_LIMIT = 4
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic resetn,
  // Decoded management access.
  input wire logic mgmt_c45,
  input wire logic [15:0] mgmt_addr,
  input wire logic mgmt_wr,
  input wire logic mgmt_rd,
  input wire logic [15:0] mgmt_wdata,
  output logic [15:0] mgmt_rdata,
  output logic mgmt_rvalid,
  // Manual rate fields held elsewhere.
  input wire logic [hsc_pkg::HSC_MULT_W-1:0] manual_pll_multiplier,
  input wire logic [hsc_pkg::HSC_MULT_W-1:0] manual_host_multiplier,
  input wire logic [hsc_pkg::HSC_RATE_W-1:0] manual_rate,
  // Effective rate settings.
  output logic [hsc_pkg::HSC_MULT_W-1:0] pll_multiplier,
  output logic [hsc_pkg::HSC_MULT_W-1:0] host_side_multiplier,
  output logic [hsc_pkg::HSC_RATE_W-1:0] side_rate,
  // Datapath steering.
  output logic rx_tolerance_comp_skip,
  output logic tx_tolerance_comp_skip,
  output logic line_encoder_skip,
  output logic line_decoder_skip,
  // Receive symbols and sync status.
  input wire logic rx_symbol_valid,
  input wire logic [9:0] rx_symbol,
  input wire logic rx_code_error,
  output logic align_match,
  output logic sync_acquired
);
  import hsc_pkg::*;

  logic [15:0] ctrl;
  logic [15:0] pointer;
  logic [HSC_CHAR_W-1:0] align_char_positive;
  logic [HSC_CHAR_W-1:0] align_char_negative;
  hsc_sel_t direct_sel;
  hsc_sel_t target_sel;
  logic [1:0] sync_loss_policy;
  logic sym_match;
  logic sym_err;
  logic sym_good;
  hsc_sync_t sync_state;
  hsc_sync_t next_sync_state;
  logic [2:0] acq_cnt;
  logic [2:0] next_acq_cnt;
  logic [2:0] err_cnt;
  logic [2:0] next_err_cnt;
  logic [2:0] good_cnt;
  logic [2:0] next_good_cnt;
  logic [1:0] run_cnt;
  logic [1:0] next_run_cnt;

  // The window and pointer live only in the base page; the extended
  // page is the block of alignment characters.
  function automatic hsc_sel_t hsc_decode(input logic [15:0] addr, input logic base_ok);
    hsc_sel_t s;
    s = HSC_SEL_NONE;
    if (base_ok && addr == HSC_OFF_CTRL) begin
      s = HSC_SEL_CTRL;
    end else if (base_ok && addr == HSC_OFF_PTR) begin
      s = HSC_SEL_PTR;
    end else if (base_ok && addr == HSC_OFF_WIN) begin
      s = HSC_SEL_WIN;
    end else if (addr == HSC_OFF_POS) begin
      s = HSC_SEL_POS;
    end else if (addr == HSC_OFF_NEG) begin
      s = HSC_SEL_NEG;
    end
    return s;
  endfunction

  function automatic logic [15:0] hsc_read(input hsc_sel_t s, input logic [15:0] c, input logic [15:0] p,
                                           input logic [9:0] pos, input logic [9:0] neg);
    logic [15:0] d;
    d = 16'h0000;
    case (s)
      HSC_SEL_CTRL: d = c;
      HSC_SEL_PTR: d = p;
      HSC_SEL_POS: d = {6'h00, pos};
      HSC_SEL_NEG: d = {6'h00, neg};
      default: d = 16'h0000;
    endcase
    return d;
  endfunction

  // Clause 22 frames carry only a 5-bit register number, so only the base page is seen there.
  always_comb begin
    if (mgmt_c45) begin
      direct_sel = hsc_decode(mgmt_addr, 1'b1);
    end else begin
      direct_sel = hsc_decode({11'h000, mgmt_addr[4:0]}, 1'b1);
    end
  end

  always_comb begin
    if (direct_sel == HSC_SEL_WIN) begin
      target_sel = hsc_decode(pointer, 1'b0);
    end else begin
      target_sel = direct_sel;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl <= HSC_RST_CTRL;
    end else if (mgmt_wr && target_sel == HSC_SEL_CTRL) begin
      ctrl <= mgmt_wdata;
    end
  end

  // pointer changes only on its own write.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pointer <= HSC_RST_PTR;
    end else if (mgmt_wr && target_sel == HSC_SEL_PTR) begin
      pointer <= mgmt_wdata;
    end
  end

  // ten-bit characters, upper bits read zero.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      align_char_positive <= HSC_RST_POS;
      align_char_negative <= HSC_RST_NEG;
    end else if (mgmt_wr && target_sel == HSC_SEL_POS) begin
      align_char_positive <= mgmt_wdata[HSC_CHAR_W-1:0];
    end else if (mgmt_wr && target_sel == HSC_SEL_NEG) begin
      align_char_negative <= mgmt_wdata[HSC_CHAR_W-1:0];
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      mgmt_rdata <= 16'h0000;
      mgmt_rvalid <= 1'b0;
    end else begin
      mgmt_rvalid <= mgmt_rd;
      if (mgmt_rd) begin
        mgmt_rdata <= hsc_read(target_sel, ctrl, pointer, align_char_positive, align_char_negative);
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pll_multiplier <= HSC_AUTO_PLL_156;
      host_side_multiplier <= HSC_AUTO_HOST_156;
      side_rate <= HSC_AUTO_RATE;
    end else if (ctrl[HSC_BIT_MANUAL]) begin
      pll_multiplier <= manual_pll_multiplier;
      host_side_multiplier <= manual_host_multiplier;
      side_rate <= manual_rate;
    end else begin
      pll_multiplier <= ctrl[HSC_BIT_REFSEL] ? HSC_AUTO_PLL_312 : HSC_AUTO_PLL_156;
      host_side_multiplier <= ctrl[HSC_BIT_REFSEL] ? HSC_AUTO_HOST_312 : HSC_AUTO_HOST_156;
      side_rate <= HSC_AUTO_RATE;
    end
  end

  assign rx_tolerance_comp_skip = ctrl[HSC_BIT_RX_CTC];
  assign tx_tolerance_comp_skip = ctrl[HSC_BIT_TX_CTC];
  assign line_encoder_skip = ctrl[HSC_BIT_ENC];
  assign line_decoder_skip = ctrl[HSC_BIT_DEC];
  assign sync_loss_policy = ctrl[HSC_POL_HI:HSC_POL_LO];

  // either disparity of the alignment character.
  assign sym_match = rx_symbol_valid && (rx_symbol == align_char_positive || rx_symbol == align_char_negative);
  assign sym_err = rx_symbol_valid && rx_code_error;
  assign sym_good = rx_symbol_valid && !rx_code_error;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      align_match <= 1'b0;
    end else begin
      align_match <= sym_match;
    end
  end

  // Acquisition needs ACQ_COUNT clean alignment characters with no code error between them.
  always_comb begin
    next_sync_state = sync_state;
    next_acq_cnt = acq_cnt;
    next_err_cnt = err_cnt;
    next_good_cnt = good_cnt;
    next_run_cnt = run_cnt;
    case (sync_state)
      HSC_LOST: begin
        next_err_cnt = 3'h0;
        next_good_cnt = 3'h0;
        next_run_cnt = 2'h0;
        if (sym_err) begin
          next_acq_cnt = 3'h0;
        end else if (sym_match) begin
          if (acq_cnt + 3'h1 >= 3'(ACQ_COUNT)) begin
            next_sync_state = HSC_SYNCED;
            next_acq_cnt = 3'h0;
          end else begin
            next_acq_cnt = acq_cnt + 3'h1;
          end
        end
      end
      HSC_SYNCED: begin
        if (sync_loss_policy == HSC_POL_STD) begin
          // errors accumulate, clean runs pay them back.
          if (sym_err) begin
            next_good_cnt = 3'h0;
            if (err_cnt + 3'h1 >= 3'(ERR_LIMIT)) begin
              next_sync_state = HSC_LOST;
            end else begin
              next_err_cnt = err_cnt + 3'h1;
            end
          end else if (sym_good && err_cnt != 3'h0) begin
            if (good_cnt + 3'h1 >= 3'(GOOD_RECOVER)) begin
              next_err_cnt = err_cnt - 3'h1;
              next_good_cnt = 3'h0;
            end else begin
              next_good_cnt = good_cnt + 3'h1;
            end
          end
        end else begin
          // run length equal to the policy code.
          if (sym_err) begin
            if (run_cnt + 2'h1 >= sync_loss_policy) begin
              next_sync_state = HSC_LOST;
            end else begin
              next_run_cnt = run_cnt + 2'h1;
            end
          end else if (sym_good) begin
            next_run_cnt = 2'h0;
          end
        end
      end
      default: begin
        next_sync_state = HSC_LOST;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sync_state <= HSC_LOST;
      acq_cnt <= 3'h0;
      err_cnt <= 3'h0;
      good_cnt <= 3'h0;
      run_cnt <= 2'h0;
    end else begin
      sync_state <= next_sync_state;
      acq_cnt <= next_acq_cnt;
      err_cnt <= next_err_cnt;
      good_cnt <= next_good_cnt;
      run_cnt <= next_run_cnt;
    end
  end

  assign sync_acquired = (sync_state == HSC_SYNCED);

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  a_manual_rate_path: assert property (
    ctrl[HSC_BIT_MANUAL] |=> pll_multiplier == $past(manual_pll_multiplier)
      && host_side_multiplier == $past(manual_host_multiplier) && side_rate == $past(manual_rate))
    else $error("manual rate fields not passed through");

  a_auto_rate_choice: assert property (
    !ctrl[HSC_BIT_MANUAL] |=> pll_multiplier == ($past(ctrl[HSC_BIT_REFSEL]) ? HSC_AUTO_PLL_312 : HSC_AUTO_PLL_156))
    else $error("automatic multiplier does not follow reference choice");

  a_ctrl_write_bits: assert property (
    (mgmt_wr && direct_sel == HSC_SEL_CTRL) |=> rx_tolerance_comp_skip == $past(mgmt_wdata[HSC_BIT_RX_CTC])
      && tx_tolerance_comp_skip == $past(mgmt_wdata[HSC_BIT_TX_CTC])
      && line_encoder_skip == $past(mgmt_wdata[HSC_BIT_ENC])
      && line_decoder_skip == $past(mgmt_wdata[HSC_BIT_DEC]))
    else $error("skip bits not steered by control write");

  a_std_single_err: assert property (
    (sync_acquired && sync_loss_policy == HSC_POL_STD && err_cnt == 3'h0 && sym_err) |=> sync_acquired)
    else $error("standard hysteresis dropped sync on one error");

  a_one_err_drop: assert property (
    (sync_acquired && sync_loss_policy == HSC_POL_ONE && sym_err) |=> !sync_acquired)
    else $error("single error did not drop sync");

  a_two_err_drop: assert property (
    (sync_acquired && sync_loss_policy == HSC_POL_TWO && sym_err ##1 sym_err && sync_loss_policy == HSC_POL_TWO)
      |=> !sync_acquired)
    else $error("two consecutive errors did not drop sync");

  a_three_err_drop: assert property (
    (sync_acquired && sync_loss_policy == HSC_POL_THREE && sym_err) [*3] |=> !sync_acquired)
    else $error("three consecutive errors did not drop sync");

  a_window_read: assert property (
    (mgmt_rd && !mgmt_c45 && mgmt_addr[4:0] == HSC_OFF_WIN[4:0] && pointer == HSC_OFF_POS)
      |=> mgmt_rvalid && mgmt_rdata == {6'h00, $past(align_char_positive)})
    else $error("window read did not return pointed register");

  a_direct_ext_read: assert property (
    (mgmt_rd && mgmt_c45 && mgmt_addr == HSC_OFF_NEG) |=> mgmt_rdata == {6'h00, $past(align_char_negative)})
    else $error("clause 45 read of extended register wrong");

  a_align_match: assert property (
    (rx_symbol_valid && (rx_symbol == align_char_positive || rx_symbol == align_char_negative)) |=> align_match)
    else $error("alignment character not matched");

  a_pointer_kept: assert property (
    !(mgmt_wr && direct_sel == HSC_SEL_PTR) |=> $stable(pointer))
    else $error("pointer changed without its own write");

  c_acquire: cover property (!sync_acquired ##1 sync_acquired);
  c_window_write: cover property (mgmt_wr && direct_sel == HSC_SEL_WIN && target_sel == HSC_SEL_NEG);
  c_std_loss: cover property (sync_acquired && sync_loss_policy == HSC_POL_STD ##1 !sync_acquired);

endmodule
